// ### rtl/ibsc_pkg.sv
// Purpose: shared constants for the boot strap configuration block
// Assumes: internal clock at 50 MHz, link clock near 83 MHz
// Notes: strap word and crossing word layouts live here
//
// Functional notes
// [RL1] serial clock driven onto the bus never exceeds 100 kHz
// [RL2] load-disable strap high skips the boot load, low performs it
// [RL3] straps held 10 internal cycles after reset; sampled inside that window
// [RL4] strap changes after the sampling window are ignored
// [RL5] load-disable strap never blocks slave accesses
// [RL6] multibyte strap high selects multi-byte addressing, low single-byte
// [RL7] slave-address straps form the low 2 bits of own 7-bit address
// [RL8] software may replace the strap-derived slave address bits
// [RL9] pin-select high: slave straps also give low two EEPROM address bits
// [RL10] pin-select low: EEPROM address low bits are 00
// [RL11] software may override the EEPROM address low bits
// [RL12] serial data pin is open-drain, both sending and receiving
// [RL13] hard reset is active low, asynchronous, resets everything
// [RL14] straps captured into holding registers; only copies used afterwards
`default_nettype none

package ibsc_pkg;

  // strap sampling window, in internal clock cycles
  localparam int         STRAP_HOLD_CYC   = 10;
  localparam int         STRAP_SAMPLE_CYC = 8;
  localparam logic [3:0] SAMPLE_LAST      = 4'(STRAP_SAMPLE_CYC - 1);

  // filtered strap vector layout
  localparam int         STRAP_W      = 5;
  localparam int         STRAP_LD     = 4;
  localparam int         STRAP_MB     = 3;
  localparam int         STRAP_SEL    = 2;
  localparam int         STRAP_SA_LSB = 0;
  localparam logic [4:0] STRAP_RST    = 5'h00;

  // addresses
  localparam int         ADDR_LOW_W  = 2;
  localparam int         ADDR_HI_W   = 5;
  localparam logic [1:0] EE_LOW_DFLT = 2'h0;
  // upper address bits: values are arbitrary
  localparam logic [4:0] SLAVE_HI_DFLT  = 5'h0b;
  localparam logic [4:0] EEPROM_HI_DFLT = 5'h14;

  // word carried into the link domain
  localparam int         CFG_W      = 6;
  localparam int         CFG_LD     = 5;
  localparam int         CFG_MB     = 4;
  localparam int         CFG_SA_LSB = 2;
  localparam int         CFG_EE_LSB = 0;
  localparam logic [5:0] CFG_RST    = 6'h00;

  // serial clock timing
  localparam int         SCL_MAX_HZ   = 100_000;
  localparam int         LINK_CLK_HZ  = 83_333_333;
  localparam int         SCL_HALF_CYC =
    (LINK_CLK_HZ + 2 * SCL_MAX_HZ - 1) / (2 * SCL_MAX_HZ);
  localparam int         SCL_CNT_W     = 10;
  localparam logic [9:0] SCL_HALF_LAST = 10'(SCL_HALF_CYC - 1);
  localparam logic [9:0] SCL_CNT_MAX   = 10'h3ff;

  function automatic logic [6:0] addr_join(input logic [4:0] hi,
                                           input logic [1:0] lo);
    addr_join = {hi, lo};
  endfunction : addr_join

endpackage : ibsc_pkg

`default_nettype wire

// ### rtl/ibsc_sync3.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_i
// Notes: output follows only when stages two and three agree
`default_nettype none

module ibsc_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
    end
    else
    begin
      ff1_reg <= d_i;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          q_reg[g] <= 1'b0;
        else if (ff2_reg[g] == ff3_reg[g])
          q_reg[g] <= ff3_reg[g];
      end
    end
  endgenerate

  assign q_o = q_reg;

endmodule : ibsc_sync3

`default_nettype wire

// ### rtl/ibsc_sampler.sv
// Purpose: one-shot strap capture after reset release
// Assumes: strap_i already synchronised and filtered
// Notes: capture cycle sits inside the hold window to leave sync margin
`default_nettype none

module ibsc_sampler (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // filtered straps
  input  wire logic [4:0] strap_i,
  // captured copies
  output logic            done_o,
  output logic            load_dis_o,
  output logic            mb_o,
  output logic            pin_sel_o,
  output logic [1:0]      sa_o
);

  logic [3:0] cnt_reg;
  logic       done_reg;
  logic [4:0] cap_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_reg <= 4'h0;
    else if (!done_reg)
      cnt_reg <= 4'(cnt_reg + 4'h1);
  end

  // window closes for good; later strap motion never reaches cap_reg
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done_reg <= 1'b0;
    else if (!done_reg && cnt_reg == ibsc_pkg::SAMPLE_LAST)
      done_reg <= 1'b1; // [RL3] [RL4]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cap_reg <= ibsc_pkg::STRAP_RST;
    else if (!done_reg && cnt_reg == ibsc_pkg::SAMPLE_LAST)
      cap_reg <= strap_i; // [RL14]
  end

  assign done_o     = done_reg;
  assign load_dis_o = cap_reg[ibsc_pkg::STRAP_LD];
  assign mb_o       = cap_reg[ibsc_pkg::STRAP_MB]; // [RL6]
  assign pin_sel_o  = cap_reg[ibsc_pkg::STRAP_SEL];
  assign sa_o       = cap_reg[ibsc_pkg::STRAP_SA_LSB +: 2];

  sample_window_a: assert property (@(posedge clk_i) // [RL3]
    $fell(rst_i) |-> (!done_reg) [*8] ##1 done_reg)
    else $error("strap capture not at the expected cycle");

  strap_frozen_a: assert property (@(posedge clk_i) disable iff (rst_i)
    done_reg && $past(done_reg) |-> $stable(cap_reg)) // [RL4]
    else $error("captured straps moved after the window");

  capture_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done_reg) |-> cap_reg == $past(strap_i)) // [RL14]
    else $error("captured straps differ from filtered inputs");

endmodule : ibsc_sampler

`default_nettype wire

// ### rtl/ibsc_top.sv
// Purpose: strap capture, address selection and bus pins of the boot loader
// Assumes: sys_clk_i 50 MHz, link_clk_i free running
// Notes: config crosses by a toggle handshake; word stays put while busy
`default_nettype none

module ibsc_top #(
  parameter logic [4:0] SLAVE_ADDR_HI  = ibsc_pkg::SLAVE_HI_DFLT,
  parameter logic [4:0] EEPROM_ADDR_HI = ibsc_pkg::EEPROM_HI_DFLT
) (
  // clocks and resets
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       hard_rst_n_i,
  input  wire logic       link_clk_i,
  // strap pins
  input  wire logic       load_disable_strap_i,
  input  wire logic       multibyte_addr_strap_i,
  input  wire logic [1:0] slave_addr_low_straps_i,
  input  wire logic       pin_select_strap_i,
  // software overrides, sys domain
  input  wire logic       sw_slave_low_wr_i,
  input  wire logic [1:0] sw_slave_low_i,
  input  wire logic       sw_eeprom_low_wr_i,
  input  wire logic [1:0] sw_eeprom_low_i,
  // status, sys domain
  output logic            cfg_done_o,
  output logic            load_disabled_o,
  output logic            multibyte_o,
  output logic [6:0]      slave_addr_o,
  output logic [6:0]      eeprom_addr_o,
  // config, link domain
  output logic            link_cfg_valid_o,
  output logic            link_load_start_o,
  output logic            link_multibyte_o,
  output logic [6:0]      link_slave_addr_o,
  output logic [6:0]      link_eeprom_addr_o,
  // engine side, link domain
  input  wire logic       eng_scl_run_i,
  input  wire logic       eng_sda_low_i,
  output logic            eng_scl_fall_o,
  output logic            eng_scl_o,
  output logic            eng_sda_o,
  // bus pins
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       serial_bus_data_pin_i,
  output logic            serial_bus_data_pin_o,
  output logic            serial_bus_data_pin_oe_o
);

  typedef enum logic [1:0] {SCL_IDLE, SCL_LOW, SCL_HIGH} ibsc_scl_state_t;

  logic            hr1_reg;
  logic            hr2_reg;
  logic            sys_rst;
  logic            lr1_reg;
  logic            lr2_reg;
  logic            link_rst;
  logic [4:0]      strap_filt;
  logic            done;
  logic            cap_ld;
  logic            cap_mb;
  logic            cap_sel;
  logic [1:0]      cap_sa;
  logic            sa_ovr_v_reg;
  logic [1:0]      sa_ovr_reg;
  logic            ee_ovr_v_reg;
  logic [1:0]      ee_ovr_reg;
  logic [1:0]      sa_low_next;
  logic [1:0]      ee_low_next;
  logic [1:0]      sa_low_reg;
  logic [1:0]      ee_low_reg;
  logic [5:0]      word_next;
  logic [5:0]      sent_reg;
  logic            sent_once_reg;
  logic            req_tgl_reg;
  logic            busy_reg;
  logic            ak1_reg;
  logic            ak2_reg;
  logic            ak3_reg;
  logic            ack_edge;
  logic            send;
  logic            rq1_reg;
  logic            rq2_reg;
  logic            rq3_reg;
  logic            req_edge;
  logic [5:0]      word_l_reg;
  logic            ack_tgl_reg;
  logic            cfg_valid_reg;
  logic            load_issued_reg;
  logic            load_start_reg;
  logic [1:0]      pin_filt;
  logic            scl_s;
  logic            sda_s;
  ibsc_scl_state_t scl_state_reg;
  logic [9:0]      scl_cnt_reg;
  logic            scl_oe_reg;
  logic            scl_fall_reg;
  logic            sda_oe_reg;
  logic            oe_prev_reg;
  logic [9:0]      hold_cnt_reg;

  // hard reset asserts at once, releases on the clock
  always_ff @(posedge sys_clk_i or negedge hard_rst_n_i)
  begin
    if (!hard_rst_n_i)
    begin
      hr1_reg <= 1'b1; // [RL13]
      hr2_reg <= 1'b1;
    end
    else
    begin
      hr1_reg <= 1'b0;
      hr2_reg <= hr1_reg;
    end
  end

  assign sys_rst = rst_i | hr2_reg;

  always_ff @(posedge link_clk_i or negedge hard_rst_n_i)
  begin
    if (!hard_rst_n_i)
    begin
      lr1_reg <= 1'b1; // [RL13]
      lr2_reg <= 1'b1;
    end
    else
    begin
      lr1_reg <= sys_rst;
      lr2_reg <= lr1_reg;
    end
  end

  assign link_rst = lr2_reg;

  ibsc_sync3 #(
    .W (ibsc_pkg::STRAP_W)
  ) u_strap_sync (
    .clk_i (sys_clk_i),
    .rst_i (sys_rst),
    .d_i   ({load_disable_strap_i, multibyte_addr_strap_i,
             pin_select_strap_i, slave_addr_low_straps_i}),
    .q_o   (strap_filt)
  );

  ibsc_sampler u_sampler (
    .clk_i      (sys_clk_i),
    .rst_i      (sys_rst),
    .strap_i    (strap_filt),
    .done_o     (done),
    .load_dis_o (cap_ld),
    .mb_o       (cap_mb),
    .pin_sel_o  (cap_sel),
    .sa_o       (cap_sa)
  );

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst)
    begin
      sa_ovr_v_reg <= 1'b0;
      sa_ovr_reg   <= 2'h0;
    end
    else if (sw_slave_low_wr_i)
    begin
      sa_ovr_v_reg <= 1'b1; // [RL8]
      sa_ovr_reg   <= sw_slave_low_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst)
    begin
      ee_ovr_v_reg <= 1'b0;
      ee_ovr_reg   <= 2'h0;
    end
    else if (sw_eeprom_low_wr_i)
    begin
      ee_ovr_v_reg <= 1'b1; // [RL11]
      ee_ovr_reg   <= sw_eeprom_low_i;
    end
  end

  always_comb
  begin
    sa_low_next = sa_ovr_v_reg ? sa_ovr_reg : cap_sa; // [RL7] [RL8]
    if (ee_ovr_v_reg)
      ee_low_next = ee_ovr_reg; // [RL11]
    else if (cap_sel)
      ee_low_next = cap_sa; // [RL9]
    else
      ee_low_next = ibsc_pkg::EE_LOW_DFLT; // [RL10]
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst)
    begin
      sa_low_reg <= 2'h0;
      ee_low_reg <= ibsc_pkg::EE_LOW_DFLT;
    end
    else
    begin
      sa_low_reg <= sa_low_next;
      ee_low_reg <= ee_low_next;
    end
  end

  assign cfg_done_o      = done;
  assign load_disabled_o = cap_ld;
  assign multibyte_o     = cap_mb;
  assign slave_addr_o    = ibsc_pkg::addr_join(SLAVE_ADDR_HI, sa_low_reg);
  assign eeprom_addr_o   = ibsc_pkg::addr_join(EEPROM_ADDR_HI, ee_low_reg);

  // only captured copies feed the link; raw straps never cross
  // next values, so the first word already carries the strap address bits
  assign word_next = {cap_ld, cap_mb, sa_low_next, ee_low_next}; // [RL14]
  assign send = done && !busy_reg &&
                (!sent_once_reg || word_next != sent_reg);

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst)
    begin
      sent_reg      <= ibsc_pkg::CFG_RST;
      sent_once_reg <= 1'b0;
      req_tgl_reg   <= 1'b0;
    end
    else if (send)
    begin
      sent_reg      <= word_next;
      sent_once_reg <= 1'b1;
      req_tgl_reg   <= ~req_tgl_reg;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst)
    begin
      ak1_reg <= 1'b0;
      ak2_reg <= 1'b0;
      ak3_reg <= 1'b0;
    end
    else
    begin
      ak1_reg <= ack_tgl_reg;
      ak2_reg <= ak1_reg;
      ak3_reg <= ak2_reg;
    end
  end

  assign ack_edge = ak2_reg ^ ak3_reg;

  // sent_reg must not move until the link side has taken it
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst)
      busy_reg <= 1'b0;
    else if (ack_edge)
      busy_reg <= 1'b0;
    else if (send)
      busy_reg <= 1'b1;
  end

  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      rq1_reg <= 1'b0;
      rq2_reg <= 1'b0;
      rq3_reg <= 1'b0;
    end
    else
    begin
      rq1_reg <= req_tgl_reg;
      rq2_reg <= rq1_reg;
      rq3_reg <= rq2_reg;
    end
  end

  assign req_edge = rq2_reg ^ rq3_reg;

  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      word_l_reg    <= ibsc_pkg::CFG_RST;
      ack_tgl_reg   <= 1'b0;
      cfg_valid_reg <= 1'b0;
    end
    else if (req_edge)
    begin
      word_l_reg    <= sent_reg;
      ack_tgl_reg   <= ~ack_tgl_reg;
      cfg_valid_reg <= 1'b1; // [RL5]
    end
  end

  // boot load is requested once per reset, never on later overrides
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      load_issued_reg <= 1'b0;
      load_start_reg  <= 1'b0;
    end
    else
    begin
      load_start_reg <= req_edge && !load_issued_reg &&
                        !sent_reg[ibsc_pkg::CFG_LD]; // [RL2]
      if (req_edge)
        load_issued_reg <= 1'b1;
    end
  end

  assign link_cfg_valid_o   = cfg_valid_reg;
  assign link_load_start_o  = load_start_reg;
  assign link_multibyte_o   = word_l_reg[ibsc_pkg::CFG_MB]; // [RL6]
  assign link_slave_addr_o  = ibsc_pkg::addr_join(SLAVE_ADDR_HI,
    word_l_reg[ibsc_pkg::CFG_SA_LSB +: 2]);
  assign link_eeprom_addr_o = ibsc_pkg::addr_join(EEPROM_ADDR_HI,
    word_l_reg[ibsc_pkg::CFG_EE_LSB +: 2]);

  ibsc_sync3 #(
    .W (2)
  ) u_pin_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst),
    .d_i   ({scl_i, serial_bus_data_pin_i}),
    .q_o   (pin_filt)
  );

  assign scl_s = pin_filt[1];
  assign sda_s = pin_filt[0];

  // high phase counts only while the wire is seen high: honours stretching
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      scl_state_reg <= SCL_IDLE;
      scl_cnt_reg   <= 10'h000;
      scl_oe_reg    <= 1'b0;
      scl_fall_reg  <= 1'b0;
    end
    else
    begin
      scl_fall_reg <= 1'b0;
      case (scl_state_reg)
        SCL_IDLE:
        begin
          if (eng_scl_run_i)
          begin
            scl_state_reg <= SCL_LOW;
            scl_oe_reg    <= 1'b1;
            scl_cnt_reg   <= 10'h000;
            scl_fall_reg  <= 1'b1;
          end
        end
        SCL_LOW:
        begin
          if (scl_cnt_reg == ibsc_pkg::SCL_HALF_LAST)
          begin
            scl_state_reg <= SCL_HIGH; // [RL1]
            scl_oe_reg    <= 1'b0;
            scl_cnt_reg   <= 10'h000;
          end
          else
            scl_cnt_reg <= 10'(scl_cnt_reg + 10'h001);
        end
        SCL_HIGH:
        begin
          if (scl_s && scl_cnt_reg == ibsc_pkg::SCL_HALF_LAST)
          begin
            scl_cnt_reg <= 10'h000; // [RL1]
            if (eng_scl_run_i)
            begin
              scl_state_reg <= SCL_LOW;
              scl_oe_reg    <= 1'b1;
              scl_fall_reg  <= 1'b1;
            end
            else
              scl_state_reg <= SCL_IDLE;
          end
          else if (scl_s)
            scl_cnt_reg <= 10'(scl_cnt_reg + 10'h001);
        end
        default:
        begin
          scl_state_reg <= SCL_IDLE;
          scl_oe_reg    <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
      sda_oe_reg <= 1'b0;
    else
      sda_oe_reg <= eng_sda_low_i; // [RL12]
  end

  assign scl_o                    = 1'b0;
  assign scl_oe_o                 = scl_oe_reg;
  assign serial_bus_data_pin_o    = 1'b0; // [RL12]
  assign serial_bus_data_pin_oe_o = sda_oe_reg;
  assign eng_scl_fall_o           = scl_fall_reg;
  assign eng_scl_o                = scl_s;
  assign eng_sda_o                = sda_s; // [RL12]

  // helper: cycles the clock drive has held its level
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      oe_prev_reg  <= 1'b0;
      hold_cnt_reg <= 10'h000;
    end
    else
    begin
      oe_prev_reg <= scl_oe_reg;
      if (scl_oe_reg != oe_prev_reg)
        hold_cnt_reg <= 10'h001;
      else if (hold_cnt_reg != ibsc_pkg::SCL_CNT_MAX)
        hold_cnt_reg <= 10'(hold_cnt_reg + 10'h001);
    end
  end

  scl_low_time_a: assert property (@(posedge link_clk_i)
    disable iff (link_rst) // [RL1]
    (scl_oe_reg != oe_prev_reg) && oe_prev_reg |->
      hold_cnt_reg >= 10'(ibsc_pkg::SCL_HALF_CYC))
    else $error("serial clock low phase too short");

  load_gate_a: assert property (@(posedge link_clk_i)
    disable iff (link_rst) // [RL2]
    load_start_reg |-> !word_l_reg[ibsc_pkg::CFG_LD] && cfg_valid_reg)
    else $error("load started while disabled");

  load_fire_a: assert property (@(posedge link_clk_i)
    disable iff (link_rst) // [RL2]
    $rose(cfg_valid_reg) && !word_l_reg[ibsc_pkg::CFG_LD] |->
      load_start_reg ##1 !load_start_reg)
    else $error("enabled load not started exactly once");

  slave_open_a: assert property (@(posedge link_clk_i)
    disable iff (link_rst) // [RL5]
    $rose(cfg_valid_reg) |-> link_cfg_valid_o [*8])
    else $error("slave access withheld");

  slave_low_a: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst) // [RL7]
    done && !sa_ovr_v_reg && $past(done) |-> sa_low_reg == cap_sa)
    else $error("slave low bits not from straps");

  eeprom_low_a: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst) // [RL9] [RL10]
    done && $past(done) && !ee_ovr_v_reg |->
      ee_low_reg == (cap_sel ? cap_sa : ibsc_pkg::EE_LOW_DFLT))
    else $error("eeprom low bits wrong for pin select");

  slave_ovr_a: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst) // [RL8]
    sw_slave_low_wr_i ##1 !sw_slave_low_wr_i |->
      ##1 sa_low_reg == $past(sw_slave_low_i, 2))
    else $error("slave override not applied");

  eeprom_ovr_a: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst) // [RL11]
    sw_eeprom_low_wr_i ##1 !sw_eeprom_low_wr_i |->
      ##1 ee_low_reg == $past(sw_eeprom_low_i, 2))
    else $error("eeprom override not applied");

  sda_drive_a: assert property (@(posedge link_clk_i)
    disable iff (link_rst) // [RL12]
    eng_sda_low_i |=> serial_bus_data_pin_oe_o && !serial_bus_data_pin_o)
    else $error("data line not pulled low");

  hard_reset_a: assert property (@(posedge sys_clk_i) // [RL13]
    !hard_rst_n_i |-> sys_rst ##1 !cfg_done_o)
    else $error("hard reset not holding the block");

endmodule : ibsc_top

`default_nettype wire

// ### sim/ibsc_bus_model.sv
// Purpose: far side of the two-wire bus with pull-ups on both wires
// Assumes: device pins pull low when their enable is high
// Notes: stretch_i holds the clock low after the device lets it go
`default_nettype none

module ibsc_bus_model (
  // device pin enables
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  // far side behaviour
  input  wire logic sda_low_i,
  input  wire logic [31:0] stretch_i,
  // wire levels
  output logic      scl_w_o,
  output logic      sda_w_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_low = 1'b0;

  // wired-and of all parties, pull-up when nobody drives
  assign scl_w_o = ~(scl_oe_i | hold_low);
  assign sda_w_o = ~(sda_oe_i | sda_low_i);

  // a slow peripheral keeps the clock low a while longer
  always @(negedge scl_oe_i)
  begin
    hold_low = 1'b1;
    #(stretch_i);
    hold_low = 1'b0;
  end
endmodule : ibsc_bus_model

`default_nettype wire

// ### sim/i2c_boot_strap_config_tb.sv
// Purpose: self-checking bench of the strap capture block
// Assumes: design asserts its own timing relations internally
// Notes: link outputs are checked from a queue of notes
`default_nettype none

module i2c_boot_strap_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, link_clk_i = 0, rst_i = 1, hrst_n = 0;
  logic ld = 0, mb = 0, sel = 0, s_wr = 0, e_wr = 0;
  logic run = 0, sda_low = 0, part_low = 0;
  logic [1:0] sa = 0, s_d = 0, e_d = 0, slo, elo;
  logic done, ld_o, mb_o, lv, ls, lmb, fall, escl, esda;
  logic scl_o, scl_oe, sd_o, sd_oe, scl_w, sda_w;
  logic [6:0] sa_o, ee_o, lsa, lee;
  logic [15:0] notes[$];
  logic [15:0] exp_w;
  int seed = 32'h0ae65c67, mismatches = 0, n_compared = 0, str = 0;
  realtime t1;

  always #10 sys_clk_i = ~sys_clk_i;
  always #6 link_clk_i = ~link_clk_i;

  ibsc_top i_ibsc_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .hard_rst_n_i(hrst_n), .link_clk_i(link_clk_i),
    .load_disable_strap_i(ld), .multibyte_addr_strap_i(mb),
    .slave_addr_low_straps_i(sa), .pin_select_strap_i(sel),
    .sw_slave_low_wr_i(s_wr), .sw_slave_low_i(s_d),
    .sw_eeprom_low_wr_i(e_wr), .sw_eeprom_low_i(e_d),
    .cfg_done_o(done), .load_disabled_o(ld_o), .multibyte_o(mb_o),
    .slave_addr_o(sa_o), .eeprom_addr_o(ee_o),
    .link_cfg_valid_o(lv), .link_load_start_o(ls),
    .link_multibyte_o(lmb), .link_slave_addr_o(lsa),
    .link_eeprom_addr_o(lee), .eng_scl_run_i(run),
    .eng_sda_low_i(sda_low), .eng_scl_fall_o(fall), .eng_scl_o(escl),
    .eng_sda_o(esda), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .serial_bus_data_pin_i(sda_w), .serial_bus_data_pin_o(sd_o),
    .serial_bus_data_pin_oe_o(sd_oe));

  ibsc_bus_model i_ibsc_bus_model (.scl_oe_i(scl_oe), .sda_oe_i(sd_oe),
    .sda_low_i(part_low), .stretch_i(str), .scl_w_o(scl_w),
    .sda_w_o(sda_w));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    chk(16'(notes.size()), 16'h0);
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  function automatic logic [15:0] note(input logic st, input logic m,
                                       input logic [1:0] s,
                                       input logic [1:0] e);
    note = {st, m, ibsc_pkg::SLAVE_HI_DFLT, s, ibsc_pkg::EEPROM_HI_DFLT, e};
  endfunction : note

  // a new link word is any change of the slave or eeprom address while valid, or valid rising
  initial
  begin
    logic pv;
    logic [13:0] pa;
    pv = 0;
    pa = 0;
    forever
    begin
      @(negedge link_clk_i);
      if (lv === 1'b1 && (pv !== 1'b1 || {lsa, lee} !== pa))
        chk({ls, lmb, lsa, lee}, notes.pop_front());
      pv = lv;
      pa = {lsa, lee};
    end
  end

  task automatic sys_cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : sys_cyc

  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      sys_cyc(1);
      {rst_i, hrst_n} = i[0] ? 2'b00 : 2'b11;
      {ld, mb, sel} = i[2:0] ^ 3'h5;
      sa = 2'($random(seed));
      slo = sa;
      elo = sel ? sa : 2'h0;
      // the monitor pops notes early, so keep a private copy
      exp_w = note(~ld, mb, slo, elo);
      notes.push_back(exp_w);
      sys_cyc(8);
      {rst_i, hrst_n} = 2'b01;
      // hard release passes a two-stage synchroniser first
      sys_cyc(ibsc_pkg::STRAP_HOLD_CYC + (i[0] ? 2 : 0));
      {ld, mb, sel, sa} = 5'($random(seed));
      sys_cyc(30);
      chk({done, ld_o, mb_o}, {1'b1, ~exp_w[15], exp_w[14]});
      chk({sa_o, ee_o}, exp_w[13:0]);
      s_d = slo ^ 2'($unsigned($random(seed)) % 3 + 1);
      e_d = ~elo;
      exp_w = note(1'b0, exp_w[14], s_d, e_d);
      notes.push_back(exp_w);
      {s_wr, e_wr} = 2'b11;
      sys_cyc(1);
      {s_wr, e_wr} = 2'b00;
      sys_cyc(2);
      chk({sa_o, ee_o}, exp_w[13:0]);
      sys_cyc(60);
    end
    str = 300;
    @(posedge link_clk_i);
    #1 run = 1;
    @(posedge fall);
    t1 = $realtime;
    @(posedge fall);
    chk(16'($realtime - t1 >= 10000.0), 16'h1);
    #1 chk({scl_oe, scl_w, scl_o}, 16'h4);
    sda_low = 1;
    repeat (8) @(posedge link_clk_i);
    #1 chk({sd_oe, sd_o, sda_w, esda, escl}, 16'h10);
    sda_low = 0;
    part_low = 1;
    repeat (8) @(posedge link_clk_i);
    #1 chk({sd_oe, sda_w, esda}, 16'h0);
    part_low = 0;
    run = 0;
    repeat (8) @(posedge link_clk_i);
    #1 chk({sd_oe, esda}, 16'h1);
    conclude();
  end

  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule : i2c_boot_strap_config_tb

`default_nettype wire
